// ---- dv/npg_gate_sva.sv ----
// npg_gate port checker
// assumes: one clock, sync active-low reset, bound below
`timescale 1ns/1ps
`default_nettype none
module npg_gate_sva (
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  input wire logic       i_req,
  input wire logic [1:0] i_src,
  input wire logic [1:0] i_op,
  input wire logic       i_sel_eeprom,
  input wire logic       i_sel_cfg,
  input wire logic       o_done,
  input wire logic       o_refused,
  input wire logic       o_busy,
  input wire logic       o_flash_code_protect,
  input wire logic [1:0] o_self_write_protect_region
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  logic        tk;
  logic        fw;
  logic [13:0] bsy_q;
  assign tk = i_req && !o_busy && !o_done;
  assign fw = tk && !i_sel_eeprom && !i_sel_cfg;
  // length of the running timed op, so its end can be judged
  always @(posedge i_clk_sys) bsy_q <= (i_reset_n && o_busy) ? bsy_q + 14'h1 : 14'h0;
  a_refuse_untimed: assert property (o_refused |-> o_done && !$past(o_busy))
    else $error("bad refusal");
  a_indirect_ro: assert property (tk && i_src == 2'h0 && i_op != 2'h0 |=> o_refused)
    else $error("indirect write taken");
  a_cpu_bulk: assert property (tk && i_src != 2'h2 && i_op == 2'h3 |=> o_refused)
    else $error("cpu bulk taken");
  a_timed_len: assert property (o_done && |bsy_q |-> bsy_q inside {14'h0fb, 14'h20fb})
    else $error("bad timed length");
  a_cp_read: assert property (
    fw && i_src == 2'h2 && i_op == 2'h0 && o_flash_code_protect |=> o_refused)
    else $error("protected read taken");
  a_wrt_block: assert property (
    fw && i_src == 2'h1 && i_op == 2'h1 && o_self_write_protect_region == 2'h0 |=> o_refused)
    else $error("protected self write taken");
  a_ee_self: assert property (tk && i_src == 2'h1 && i_op == 2'h1 && i_sel_eeprom |=> o_busy)
    else $error("self write not started");
  a_cp_kept: assert property ($fell(o_flash_code_protect) |-> $past(o_busy) || $past(o_busy, 2))
    else $error("protection lost");
endmodule // npg_gate_sva
bind npg_gate npg_gate_sva chk_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req(i_req),
  .i_src(i_src), .i_op(i_op), .i_sel_eeprom(i_sel_eeprom), .i_sel_cfg(i_sel_cfg),
  .o_done(o_done), .o_refused(o_refused), .o_busy(o_busy),
  .o_flash_code_protect(o_flash_code_protect),
  .o_self_write_protect_region(o_self_write_protect_region));
`default_nettype wire

// ---- dv/npg_host.sv ----
// cpu and programmer request model for npg_gate
// assumes: acc is called at a falling edge
`timescale 1ns/1ps
`default_nettype none
module npg_host (
  input  wire logic        i_clk_sys,
  input  wire logic        i_done,
  input  wire logic        i_refused,
  output var  logic        o_req,
  output var  logic [1:0]  o_src,
  output var  logic [1:0]  o_op,
  output var  logic        o_sel_eeprom,
  output var  logic        o_sel_cfg,
  output var  logic [12:0] o_addr,
  output var  logic [13:0] o_wdata
);
  logic hung;
  initial {o_req, o_src, o_op, o_sel_eeprom, o_sel_cfg, o_addr, o_wdata} = '0;
  initial hung = 1'b0;
  // held until done; address and data scrambled once released
  task automatic acc(input logic [1:0] s, op, input logic e, c,
                     input logic [12:0] a, input logic [13:0] d, output logic rf);
    int n;
    {o_src, o_op, o_sel_eeprom, o_sel_cfg, o_addr, o_wdata} = {s, op, e, c, a, d};
    o_req = 1'b1;
    n = 0;
    while (i_done !== 1'b1 && n < 9000) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (i_done !== 1'b1)
      hung = 1'b1;
    rf = i_refused;
    o_req = 1'b0;
    {o_addr, o_wdata} = {~a, ~d};
    @(negedge i_clk_sys);
  endtask
endmodule // npg_host
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for npg_gate
// assumes: npg_host drives requests, checker bound in its own file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clk_sys, i_reset_n, rq, se, sc, dn, rfd, by, fc, ec, rf;
  logic [1:0]  sr, op, wr;
  logic [12:0] ad;
  logic [13:0] wd, rd;
  int          n_errors = 0;
  int          num_checks = 0;
  npg_gate uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_req(rq), .i_src(sr),
    .i_op(op), .i_sel_eeprom(se), .i_sel_cfg(sc), .i_addr(ad), .i_wdata(wd), .o_done(dn),
    .o_refused(rfd), .o_busy(by), .o_rdata(rd), .o_flash_code_protect(fc),
    .o_eeprom_code_protect(ec), .o_self_write_protect_region(wr));
  npg_host host (.i_clk_sys(i_clk_sys), .i_done(dn), .i_refused(rfd), .o_req(rq), .o_src(sr),
    .o_op(op), .o_sel_eeprom(se), .o_sel_cfg(sc), .o_addr(ad), .o_wdata(wd));
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic t_bulk;
    host.acc(2'h2, 2'h3, 1'b0, 1'b0, 13'h0, 14'h0, rf);
    chk(rf === 1'b0 && fc === 1'b0 && ec === 1'b0 && wr === 2'h3, "bulk state");
    host.acc(2'h1, 2'h0, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rd === 14'h3fff, "not blank");
    host.acc(2'h1, 2'h0, 1'b1, 1'b0, 13'h5, 14'h0, rf);
    chk(rd === 14'h00ff, "eeprom not blank");
    host.acc(2'h1, 2'h0, 1'b0, 1'b1, 13'h4, 14'h0, rf);
    chk(rd === 14'h3fff, "user id not blank");
  endtask
  task automatic t_self;
    host.acc(2'h1, 2'h1, 1'b0, 1'b0, 13'h10, 14'h1234, rf);
    host.acc(2'h1, 2'h1, 1'b0, 1'b0, 13'h10, 14'h3f00, rf);
    host.acc(2'h0, 2'h1, 1'b0, 1'b0, 13'h10, 14'h0, rf);
    chk(rf === 1'b1, "indirect write");
    host.acc(2'h0, 2'h0, 1'b0, 1'b0, 13'h10, 14'h0, rf);
    chk(rd === 14'h1200, "and programming");
    host.acc(2'h1, 2'h2, 1'b0, 1'b0, 13'h13, 14'h0, rf);
    host.acc(2'h1, 2'h0, 1'b0, 1'b0, 13'h10, 14'h0, rf);
    chk(rf === 1'b0 && rd === 14'h3fff, "row not erased");
  endtask
  task automatic t_wrt;
    host.acc(2'h2, 2'h1, 1'b0, 1'b1, 13'h2, 14'h3ffc, rf);
    host.acc(2'h1, 2'h1, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rf === 1'b1 && wr === 2'h0, "region write");
    host.acc(2'h2, 2'h0, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rd === 14'h3fff, "blocked write landed");
    host.acc(2'h2, 2'h1, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    host.acc(2'h2, 2'h0, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rd === 14'h0, "programmer write");
  endtask
  task automatic t_cp;
    host.acc(2'h2, 2'h1, 1'b0, 1'b1, 13'h0, 14'h3ffe, rf);
    host.acc(2'h2, 2'h1, 1'b0, 1'b1, 13'h1, 14'h3ffe, rf);
    host.acc(2'h2, 2'h0, 1'b1, 1'b0, 13'h5, 14'h0, rf);
    chk(rf === 1'b1 && fc === 1'b1 && ec === 1'b1, "eeprom read open");
    host.acc(2'h2, 2'h0, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rf === 1'b1, "flash read open");
    host.acc(2'h2, 2'h1, 1'b0, 1'b0, 13'h20, 14'h0, rf);
    chk(rf === 1'b1, "flash write open");
    host.acc(2'h1, 2'h1, 1'b1, 1'b0, 13'h5, 14'h05a, rf);
    host.acc(2'h1, 2'h0, 1'b1, 1'b0, 13'h5, 14'h0, rf);
    chk(rd === 14'h05a, "self write");
    host.acc(2'h1, 2'h3, 1'b0, 1'b0, 13'h0, 14'h0, rf);
    chk(rf === 1'b1 && fc === 1'b1, "cpu bulk");
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    @(negedge i_clk_sys);
    chk(fc === 1'b1 && ec === 1'b1 && wr === 2'h0, "protection lost at reset");
  endtask
  task automatic close_out;
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    i_reset_n = 1'b1;
    @(negedge i_clk_sys);
    t_bulk;
    t_self;
    t_wrt;
    t_cp;
    t_bulk;
    chk(host.hung === 1'b0, "request hung");
    close_out;
  end
  initial begin
    #400000;
    n_errors++;
    close_out;
  end
endmodule // tb_top
`default_nettype wire

// ---- hw/npg_gate.v ----
// nvm protection gate: access decision, timed write engine and arrays
// assumes: one request at a time on i_req, held until o_done; config
// protection bits live in this block and reset only by a programmer bulk erase
// arrays carry no reset value; a programmer bulk erase gives known contents
//
// Function
// [RL1] memory is reachable through the indirect pointer path and the register interface.
// [RL2] every write or erase is timed by an internal cycle counter.
// [RL3] with code protection on, programmer reads and writes of the protected memory are refused.
// [RL4] cpu self write and erase keep working while code protection is on.
// [RL5] code protection is cleared only by a programmer bulk erase; reset also forces the cp outputs low until the first clock after it ends.
// [RL6] a bulk erase clears both arrays, all config bits and the user id words.
// [RL7] cpu self write and erase of flash inside the selected protected region is blocked.
// [RL8] programmer operations ignore the write protect region.
// [RL9] erased flash reads all ones and programming only clears bits.
// [RL10] writes and erases through the indirect pointer path are refused.
// [RL11] a refused self write leaves memory untouched and starts no timer.
`timescale 1ns/1ps
`default_nettype none
`include "npg_map.vh"

module npg_gate (
  input  wire                    i_clk_sys,
  input  wire                    i_reset_n,
  input  wire                    i_req,
  input  wire [1:0]              i_src,
  input  wire [1:0]              i_op,
  input  wire                    i_sel_eeprom,
  input  wire                    i_sel_cfg,
  input  wire [`NPG_PF_AW-1:0]   i_addr,
  input  wire [`NPG_PF_DW-1:0]   i_wdata,
  output reg                     o_done,
  output reg                     o_refused,
  output reg                     o_busy,
  output reg  [`NPG_PF_DW-1:0]   o_rdata,
  output reg                     o_flash_code_protect,
  output reg                     o_eeprom_code_protect,
  output reg  [1:0]              o_self_write_protect_region
);

  localparam ST_IDLE = 2'h0;
  localparam ST_BULK = 2'h1;
  localparam ST_TIME = 2'h2;
  localparam ST_DONE = 2'h3;
  // the cycle count is worked out wide, then cut on purpose to the timer width
  localparam integer          WR_CYC_I = `NPG_WR_CYC;
  localparam [`NPG_TMR_W-1:0] WR_CYC   = WR_CYC_I[`NPG_TMR_W-1:0];

  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  reg [`NPG_PF_DW-1:0] pf_mem [0:`NPG_PF_WORDS-1];
  reg [`NPG_EE_DW-1:0] ee_mem [0:`NPG_EE_BYTES-1];
  // config: [0] flash cp, [1] eeprom cp, [2] region, [7:4] user id word
  reg [`NPG_PF_DW-1:0] cfg_mem [0:7];

  reg [1:0]              state_q;
  reg [`NPG_TMR_W-1:0]   tmr_q;
  reg [`NPG_PF_AW-1:0]   bulk_q;
  reg [1:0]              op_q;
  reg                    ee_q;
  reg                    cfg_q;
  reg [`NPG_PF_AW-1:0]   addr_q;
  reg [`NPG_PF_DW-1:0]   wdata_q;

  // --------------------------------------------------------------
  // access decision
  // --------------------------------------------------------------
  wire is_pgm = (i_src == `NPG_SRC_PGM);
  wire is_ind = (i_src == `NPG_SRC_IND);
  wire is_wr  = (i_op != `NPG_OP_READ);
  // config space carries no code protection of its own
  wire cp_hit = i_sel_cfg ? 1'b0 :
                (i_sel_eeprom ? o_eeprom_code_protect : o_flash_code_protect);

  // region sizes: 00 whole flash, 01 lower half, 10 lowest 512 words, 11 none
  // region 11 leaves all of flash open to self writes
  reg wp_hit;
  always @* begin
    case (o_self_write_protect_region)
      2'h0:    wp_hit = 1'b1;
      2'h1:    wp_hit = (i_addr < 13'h1000);
      2'h2:    wp_hit = (i_addr < 13'h0200);
      default: wp_hit = 1'b0;
    endcase
  end

  // indirect path is read only; bulk erase belongs to the programmer alone
  wire refuse = (is_ind && is_wr)                                         // [RL10]
              || (is_ind && i_sel_cfg)                                    // [RL1]
              || (is_pgm && cp_hit && (i_op == `NPG_OP_READ
                                   || i_op == `NPG_OP_WRITE))             // [RL3]
              || (!is_pgm && i_op == `NPG_OP_BULK_ERASE)                  // [RL5]
              || (!is_pgm && is_wr && i_sel_cfg && i_addr[2:0] < 3'h4)  // [RL5]
              || (!is_pgm && is_wr && !i_sel_eeprom && !i_sel_cfg
                  && wp_hit);                                             // [RL7] [RL8] [RL4]

  wire [`NPG_EE_AW-1:0] ee_a = i_addr[`NPG_EE_AW-1:0];
  wire [2:0]            cf_a = i_addr[2:0];

  // --------------------------------------------------------------
  // control
  // --------------------------------------------------------------
  // a request still high in the idle cycle after o_done is taken again,
  // so the caller drops i_req as soon as it sees o_done
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      tmr_q   <= {`NPG_TMR_W{1'b0}};
      bulk_q  <= {`NPG_PF_AW{1'b0}};
      op_q    <= `NPG_OP_READ;
      ee_q    <= 1'b0;
      cfg_q   <= 1'b0;
      addr_q  <= {`NPG_PF_AW{1'b0}};
      wdata_q <= {`NPG_PF_DW{1'b0}};
      o_done    <= 1'b0;
      o_refused <= 1'b0;
      o_busy    <= 1'b0;
      o_rdata   <= {`NPG_PF_DW{1'b0}};
    end else begin
      o_done    <= 1'b0;
      o_refused <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (i_req) begin
            if (refuse) begin
              o_done    <= 1'b1;                                          // [RL11]
              o_refused <= 1'b1;
            end else if (!is_wr) begin
              o_done <= 1'b1;
              if (i_sel_cfg)
                o_rdata <= cfg_mem[cf_a];
              else if (i_sel_eeprom)
                o_rdata <= {6'h00, ee_mem[ee_a]};
              else
                o_rdata <= pf_mem[i_addr];
            end else begin
              op_q    <= i_op;
              ee_q    <= i_sel_eeprom;
              cfg_q   <= i_sel_cfg;
              addr_q  <= i_addr;
              wdata_q <= i_wdata;
              o_busy  <= 1'b1;
              tmr_q   <= WR_CYC;                                          // [RL2]
              bulk_q  <= {`NPG_PF_AW{1'b0}};
              state_q <= (i_op == `NPG_OP_BULK_ERASE) ? ST_BULK : ST_TIME;
            end
          end
        end
        ST_BULK: begin
          bulk_q <= bulk_q + 1'b1;
          // config words fall in the first eight steps, so protection drops
          // early in the sweep while o_busy still stands
          if (bulk_q == {`NPG_PF_AW{1'b1}})
            state_q <= ST_TIME;
        end
        ST_TIME: begin
          tmr_q <= tmr_q - 1'b1;                                          // [RL2]
          if (tmr_q == {{(`NPG_TMR_W-1){1'b0}}, 1'b1})
            state_q <= ST_DONE;
        end
        ST_DONE: begin
          o_busy  <= 1'b0;
          o_done  <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // array updates: writes and eeprom row erase as the timed op completes, flash row and bulk erase during it
  // --------------------------------------------------------------
  // the timer doubles as the row walk: its first 32 steps each clear one
  // word of the addressed row, so no second counter is kept
  wire [`NPG_TMR_W-1:0] row_step = WR_CYC - tmr_q;
  wire                  row_live = (row_step < 10'h020);
  wire [`NPG_PF_AW-1:0] row_a    = {addr_q[`NPG_PF_AW-1:`NPG_ROW_AW],
                                    row_step[`NPG_ROW_AW-1:0]};
  always @(posedge i_clk_sys) begin
    if (state_q == ST_BULK) begin
      pf_mem[bulk_q] <= `NPG_PF_ERASED;                                  // [RL6]
      if (bulk_q[`NPG_PF_AW-1:`NPG_EE_AW] == 5'h00)
        ee_mem[bulk_q[`NPG_EE_AW-1:0]] <= `NPG_EE_ERASED;                // [RL6]
      if (bulk_q < 13'h0008)
        cfg_mem[bulk_q[2:0]] <= `NPG_PF_ERASED;                          // [RL6] [RL5]
    end else if (state_q == ST_TIME && op_q == `NPG_OP_ROW_ERASE
                 && !ee_q && !cfg_q) begin
      // one row word per cycle over the first 32 timer steps; row fits in timer span
      if (row_live)
        pf_mem[row_a] <= `NPG_PF_ERASED;                                 // [RL9]
    end else if (state_q == ST_DONE && op_q == `NPG_OP_WRITE) begin
      if (cfg_q)
        cfg_mem[addr_q[2:0]] <= cfg_mem[addr_q[2:0]] & wdata_q;
      else if (ee_q)
        ee_mem[addr_q[`NPG_EE_AW-1:0]] <= wdata_q[`NPG_EE_DW-1:0];
      else
        pf_mem[addr_q] <= pf_mem[addr_q] & wdata_q;                      // [RL9]
    end else if (state_q == ST_DONE && op_q == `NPG_OP_ROW_ERASE && ee_q) begin
      ee_mem[addr_q[`NPG_EE_AW-1:0]] <= `NPG_EE_ERASED;
    end
  end

  // --------------------------------------------------------------
  // protection outputs mirror config words (erased = unprotected)
  // --------------------------------------------------------------
  // reset forces both cp bits low and the region to 11 until the first clock after it ends; the words are nonvolatile
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_flash_code_protect        <= 1'b0;
      o_eeprom_code_protect       <= 1'b0;
      o_self_write_protect_region <= 2'h3;
    end else begin
      o_flash_code_protect        <= ~cfg_mem[0][0];                     // [RL5]
      o_eeprom_code_protect       <= ~cfg_mem[1][0];
      o_self_write_protect_region <= cfg_mem[2][1:0];
    end
  end

endmodule // npg_gate
`default_nettype wire

// ---- hw/npg_map.vh ----
// nvm protection gate: shared constants
// assumes: included by npg_gate.v only
`ifndef NPG_MAP_VH
`define NPG_MAP_VH

`define NPG_PF_AW          13
`define NPG_PF_DW          14
`define NPG_EE_AW          8
`define NPG_EE_DW          8
`define NPG_PF_WORDS       8192
`define NPG_EE_BYTES       256
`define NPG_ROW_AW         5
`define NPG_PF_ERASED      14'h3fff
`define NPG_EE_ERASED      8'hff
`define NPG_CFG_ERASED     1'b1
// indirect pointer window for eeprom: high byte 0x70
`define NPG_IND_EE_HI      8'h70
// timed write length in ns and derived cycles at 8 ns clock
`define NPG_WR_TIME_NS     2000
`define NPG_CLK_NS         8
`define NPG_WR_CYC         ((`NPG_WR_TIME_NS + `NPG_CLK_NS - 1) / `NPG_CLK_NS)
`define NPG_TMR_W          10
// access sources
`define NPG_SRC_IND        2'h0
`define NPG_SRC_REG        2'h1
`define NPG_SRC_PGM        2'h2
// operations
`define NPG_OP_READ        2'h0
`define NPG_OP_WRITE       2'h1
`define NPG_OP_ROW_ERASE   2'h2
`define NPG_OP_BULK_ERASE  2'h3

`endif
